// file: design/dsc_pkg.sv
// Functional notes
// - Cycle auto zero, integrate, deintegrate, integrator zero.
// - Integrator zeroed before every integrate phase.
// - Integrate phase held for fixed clock count.
// - Deintegrate begins within one clock of expiry.
// - Same counter and clock time deintegration.
// - Stay deintegrating until comparator changes; stop counter. Code also gives up at DINT_MAX_CYCLES and flags over-range.
// - Result is count ratio, sign opposite reference.
// - Integrator zero then auto zero clear everything.
// - Sequence repeats automatically for continuous results.
// - Integration period a multiple of mains period.
`default_nettype none
package dsc_pkg;
  // Phase codes double as the phase-select pin pattern; Gray along the cycle
  typedef enum logic [1:0] {
    DSC_PH_AZ = 2'h0,
    DSC_PH_INT = 2'h1,
    DSC_PH_DINT = 2'h3,
    DSC_PH_IZ = 2'h2
  } dsc_phase_t;

  // Clock rate
  localparam int CLK_KHZ = 250000;
  // 100 ms spans 5 periods at 50 Hz and 6 at 60 Hz
  localparam int INTEGRATION_PERIOD_MS = 100;
  localparam int INTEGRATION_CYCLES = INTEGRATION_PERIOD_MS * CLK_KHZ;
  // Zeroing phase lengths
  localparam int AZ_PERIOD_MS = 10;
  localparam int AZ_CYCLES = AZ_PERIOD_MS * CLK_KHZ;
  localparam int IZ_PERIOD_MS = 10;
  localparam int IZ_CYCLES = IZ_PERIOD_MS * CLK_KHZ;
  // Deintegration give-up point, twice the integration time
  localparam int DINT_MAX_CYCLES = 2 * INTEGRATION_CYCLES;
  // Counter width
  localparam int CNT_W = 32;
endpackage : dsc_pkg
`default_nettype wire

// file: design/dsc_sync2.sv
`default_nettype none
// Two-stage synchroniser for an asynchronous pin
module dsc_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic d_in, // Asynchronous level
  output logic q_out // Synchronised level
);
  logic meta_r;
  logic sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d_in;
      sync_r <= meta_r;
    end
  end

  assign q_out = sync_r;
endmodule : dsc_sync2
`default_nettype wire

// file: design/dsc_sequencer.sv
`default_nettype none
// Conversion controller driving the integrating analog processor
module dsc_sequencer #(
  parameter int CNT_W = dsc_pkg::CNT_W,
  parameter int INTEGRATION_CYCLES = dsc_pkg::INTEGRATION_CYCLES,
  parameter int AZ_CYCLES = dsc_pkg::AZ_CYCLES,
  parameter int IZ_CYCLES = dsc_pkg::IZ_CYCLES,
  parameter int DINT_MAX_CYCLES = dsc_pkg::DINT_MAX_CYCLES
) (
  input wire logic clk, // 250 MHz clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic run_en, // Keep converting while high
  input wire logic cmp_in, // Comparator pin, asynchronous
  output logic [1:0] phase_sel, // Phase-select pins
  output logic [CNT_W-1:0] deintegration_period, // Deintegration count
  output logic result_neg, // Measured value is negative
  output logic result_over, // Over-range on last conversion
  output logic result_valid // One-cycle pulse, new result
);
  // Refuse settings the counter cannot hold, at elaboration
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
    $error("CNT_W out of range");
  end
  if (INTEGRATION_CYCLES < 2 || AZ_CYCLES < 1 || IZ_CYCLES < 1 || DINT_MAX_CYCLES < 1) begin : g_bad_len
    $error("phase length too short");
  end
  // Wide compare: a 32-bit shift would turn negative at 31 bits
  if (64'(INTEGRATION_CYCLES) >= (64'h1 << CNT_W) || 64'(DINT_MAX_CYCLES) >= (64'h1 << CNT_W)) begin : g_bad_fit
    $error("conversion count exceeds counter");
  end
  if (64'(AZ_CYCLES) >= (64'h1 << CNT_W) || 64'(IZ_CYCLES) >= (64'h1 << CNT_W)) begin : g_bad_zero
    $error("zeroing count exceeds counter");
  end

  localparam logic [CNT_W-1:0] INT_LAST = CNT_W'(INTEGRATION_CYCLES - 1);
  localparam logic [CNT_W-1:0] AZ_LAST = CNT_W'(AZ_CYCLES - 1);
  localparam logic [CNT_W-1:0] IZ_LAST = CNT_W'(IZ_CYCLES - 1);
  localparam logic [CNT_W-1:0] DINT_LAST = CNT_W'(DINT_MAX_CYCLES - 1);

  logic cmp_sync;
  logic cmp_prev_r;
  logic cmp_fall;
  dsc_pkg::dsc_phase_t phase_r, phase_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] dint_r, dint_nxt;
  logic sign_r, sign_nxt;
  logic neg_r, neg_nxt;
  logic over_r, over_nxt;
  logic valid_r, valid_nxt;

  // Comparator resynchronised before use
  dsc_sync2 #(
    .RST_VAL(1'b1)
  ) u_cmp_sync (
    .clk(clk),
    .rstn(rstn),
    .d_in(cmp_in),
    .q_out(cmp_sync)
  );

  // Falling edge of the synchronised comparator marks the zero crossing
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmp_prev_r <= 1'b1;
    end else begin
      cmp_prev_r <= cmp_sync;
    end
  end
  assign cmp_fall = cmp_prev_r & ~cmp_sync;

  // Phase sequencing and the one shared counter
  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt = cnt_r + CNT_W'(1);
    dint_nxt = dint_r;
    sign_nxt = sign_r;
    neg_nxt = neg_r;
    over_nxt = over_r;
    valid_nxt = 1'b0;
    case (phase_r)
      dsc_pkg::DSC_PH_AZ: begin
        // Hold in auto zero when stopped; the integrator stays clamped
        if (cnt_r >= AZ_LAST) begin
          cnt_nxt = cnt_r;
          if (run_en) begin
            phase_nxt = dsc_pkg::DSC_PH_INT;
            cnt_nxt = '0;
          end
        end
      end
      dsc_pkg::DSC_PH_INT: begin
        if (cnt_r == INT_LAST) begin
          phase_nxt = dsc_pkg::DSC_PH_DINT;
          cnt_nxt = '0;
          // Comparator high means positive input, so reference goes negative
          sign_nxt = ~cmp_sync;
        end
      end
      dsc_pkg::DSC_PH_DINT: begin
        if (cmp_fall) begin
          phase_nxt = dsc_pkg::DSC_PH_IZ;
          dint_nxt = cnt_r;
          neg_nxt = sign_r;
          over_nxt = 1'b0;
          valid_nxt = 1'b1;
          cnt_nxt = '0;
        end else if (cnt_r == DINT_LAST) begin
          phase_nxt = dsc_pkg::DSC_PH_IZ;
          dint_nxt = cnt_r;
          neg_nxt = sign_r;
          over_nxt = 1'b1;
          valid_nxt = 1'b1;
          cnt_nxt = '0;
        end
      end
      dsc_pkg::DSC_PH_IZ: begin
        if (cnt_r == IZ_LAST) begin
          phase_nxt = dsc_pkg::DSC_PH_AZ;
          cnt_nxt = '0;
        end
      end
      default: begin
        phase_nxt = dsc_pkg::DSC_PH_IZ;
        cnt_nxt = '0;
      end
    endcase
  end

  // Reset starts in integrator zero so the first integrate begins from 0 V
  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_r <= dsc_pkg::DSC_PH_IZ;
      cnt_r <= '0;
      dint_r <= '0;
      sign_r <= 1'b0;
      neg_r <= 1'b0;
      over_r <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      dint_r <= dint_nxt;
      sign_r <= sign_nxt;
      neg_r <= neg_nxt;
      over_r <= over_nxt;
      valid_r <= valid_nxt;
    end
  end

  // Pins come straight from the phase register
  assign phase_sel = phase_r;
  assign deintegration_period = dint_r;
  assign result_neg = neg_r;
  assign result_over = over_r;
  assign result_valid = valid_r;

  // Checks on the sequence
  sequence s_int_done;
    phase_r == dsc_pkg::DSC_PH_INT && cnt_r == INT_LAST;
  endsequence

  sequence s_dint_start;
    phase_r == dsc_pkg::DSC_PH_DINT && cnt_r == '0;
  endsequence

  AST_PHASE_ORDER: assert property (@(posedge clk) disable iff (!rstn)
    phase_r != $past(phase_r) |->
      (phase_r == dsc_pkg::DSC_PH_INT && $past(phase_r) == dsc_pkg::DSC_PH_AZ) ||
      (phase_r == dsc_pkg::DSC_PH_DINT && $past(phase_r) == dsc_pkg::DSC_PH_INT) ||
      (phase_r == dsc_pkg::DSC_PH_IZ && $past(phase_r) == dsc_pkg::DSC_PH_DINT) ||
      (phase_r == dsc_pkg::DSC_PH_AZ && $past(phase_r) == dsc_pkg::DSC_PH_IZ))
    else $error("illegal phase step");

  AST_INT_FROM_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    $rose(phase_r == dsc_pkg::DSC_PH_INT) |-> $past(phase_r) == dsc_pkg::DSC_PH_AZ && $past(cnt_r) >= AZ_LAST)
    else $error("integrate entered without full auto zero");

  AST_INT_LENGTH: assert property (@(posedge clk) disable iff (!rstn)
    $fell(phase_r == dsc_pkg::DSC_PH_INT) |-> $past(cnt_r) == INT_LAST)
    else $error("integrate period wrong length");

  AST_DINT_PROMPT: assert property (@(posedge clk) disable iff (!rstn)
    s_int_done |=> s_dint_start)
    else $error("deintegrate late after integrate");

  AST_DINT_COUNT: assert property (@(posedge clk) disable iff (!rstn)
    s_dint_start ##1 (phase_r == dsc_pkg::DSC_PH_DINT) |-> cnt_r == CNT_W'(1))
    else $error("deintegrate counter not running");

  AST_DINT_STOP: assert property (@(posedge clk) disable iff (!rstn)
    (phase_r == dsc_pkg::DSC_PH_DINT && cmp_fall) |=>
      phase_r == dsc_pkg::DSC_PH_IZ && dint_r == $past(cnt_r) && result_valid && !result_over)
    else $error("count not stopped at crossing");

  AST_SIGN: assert property (@(posedge clk) disable iff (!rstn)
    result_valid |-> result_neg == sign_r)
    else $error("result sign mismatch");

  AST_ZERO_THEN_AZ: assert property (@(posedge clk) disable iff (!rstn)
    (phase_r == dsc_pkg::DSC_PH_IZ && cnt_r == IZ_LAST) |=> phase_r == dsc_pkg::DSC_PH_AZ && cnt_r == '0)
    else $error("integrator zero not followed by auto zero");

  AST_REPEAT: assert property (@(posedge clk) disable iff (!rstn)
    (phase_r == dsc_pkg::DSC_PH_AZ && cnt_r >= AZ_LAST && run_en) |=> phase_r == dsc_pkg::DSC_PH_INT)
    else $error("sequence did not restart");

  AST_EDGE: assert property (@(posedge clk) disable iff (!rstn)
    cmp_fall |-> !cmp_sync && $past(cmp_sync))
    else $error("false crossing edge");

  AST_OVER: assert property (@(posedge clk) disable iff (!rstn)
    (phase_r == dsc_pkg::DSC_PH_DINT && cnt_r == DINT_LAST && !cmp_fall) |=>
      result_over && result_valid && phase_r == dsc_pkg::DSC_PH_IZ)
    else $error("over-range not flagged");

  AST_SIGN_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
    s_int_done |=> sign_r == !$past(cmp_sync))
    else $error("polarity not taken at end of integrate");

  AST_VALID_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    result_valid |=> !result_valid)
    else $error("result pulse longer than one cycle");

  AST_IZ_LENGTH: assert property (@(posedge clk) disable iff (!rstn)
    $rose(phase_r == dsc_pkg::DSC_PH_AZ) |-> $past(phase_r) == dsc_pkg::DSC_PH_IZ && $past(cnt_r) == IZ_LAST)
    else $error("integrator zero wrong length");

  AST_PARK: assert property (@(posedge clk) disable iff (!rstn)
    (phase_r == dsc_pkg::DSC_PH_AZ && !run_en) |=> phase_r == dsc_pkg::DSC_PH_AZ)
    else $error("left auto zero while stopped");
endmodule : dsc_sequencer
`default_nettype wire

// file: sim/dsc_proc_model.sv
`default_nettype none
// Analog processor stand-in: the integrator ramp as seen through the comparator
module dsc_proc_model (
  input wire logic clk, // System clock
  input wire logic [1:0] phase_sel, // Phase-select pins
  input wire logic [7:0] dint_len, // Cycles to zero crossing
  input wire logic in_neg, // Input is negative
  input wire logic noise, // Chatter while zeroing
  output logic cmp_in // Comparator pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int ramp = 0;
  initial cmp_in = 1'b0;
  // Sign shows while integrating; while deintegrating ramp counts up and the comparator stays high until it reaches dint_len
  always @(posedge clk) begin
    #1;
    if (phase_sel == 2'h1) cmp_in = ~in_neg;
    else if (phase_sel == 2'h3) cmp_in = ramp < dint_len;
    else cmp_in = noise; // Unsettled while zeroing, so it chatters
    ramp = (phase_sel == 2'h3) ? ramp + 1 : 0;
  end
endmodule : dsc_proc_model
`default_nettype wire

// file: sim/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int INT_N = 64;
  localparam int DMAX = 200;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic run_en = 1'b1;
  logic noise = 1'b0;
  logic [7:0] dint_len = 8'h10;
  logic in_neg = 1'b0;
  logic cmp_in;
  logic [1:0] phase_sel;
  logic [31:0] dint_per;
  logic res_neg, res_over, res_valid;
  int errors = 0;
  int checks_done = 0;
  int seed = 32'h6a90;
  int int_len = 0;
  logic [1:0] prev_ph = 2'h2;
  logic [33:0] notes[$]; // Sign, over-range, count
  logic [31:0] d;

  always #2 clk = ~clk;

  dsc_sequencer #(.INTEGRATION_CYCLES(INT_N), .AZ_CYCLES(8), .IZ_CYCLES(8), .DINT_MAX_CYCLES(DMAX)) DUT (
    .clk(clk), .rstn(rstn), .run_en(run_en), .cmp_in(cmp_in), .phase_sel(phase_sel),
    .deintegration_period(dint_per), .result_neg(res_neg), .result_over(res_over), .result_valid(res_valid));
  dsc_proc_model model (.clk(clk), .phase_sel(phase_sel), .dint_len(dint_len), .in_neg(in_neg),
    .noise(noise), .cmp_in(cmp_in));

  task automatic check(input bit ok, input string what);
    checks_done++;
    if (!ok) begin
      errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : check
  task automatic cmp_result(input logic [33:0] e);
    check({res_neg, res_over} === e[33:32] && (^dint_per) !== 1'bx && dint_per >= e[31:0]
      && dint_per <= e[31:0] + (e[32] ? 0 : 4), "result");
  endtask : cmp_result
  // Bounded wait for a phase; returns just after the edge
  task automatic wait_phase(input logic [1:0] p);
    int n;
    n = 0;
    while (phase_sel !== p && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n < 1000, "phase never reached");
  endtask : wait_phase
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Comparator chatter while zeroing
  always @(posedge clk) begin
    #1 noise = 1'($random(seed));
  end

  // Monitor: phase order, integration length, results against notes
  always @(posedge clk) begin
    if (!rstn) int_len = 0;
    else begin
      if (phase_sel === 2'h1) int_len++;
      if (phase_sel !== prev_ph) begin
        check(phase_sel === {prev_ph[0], ~prev_ph[1]}, "phase order");
        if (prev_ph === 2'h1) check(int_len == INT_N, "integration length");
        if (prev_ph === 2'h1) int_len = 0;
      end
      if (res_valid === 1'b1 && notes.size() == 0) check(1'b0, "unexpected result");
      else if (res_valid === 1'b1) cmp_result(notes.pop_front());
    end
    prev_ph = phase_sel;
  end

  initial begin
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    // Random sign and size; every fourth conversion never crosses
    for (int i = 0; i < 13; i++) begin
      wait_phase(2'h0);
      in_neg = 1'($random(seed));
      d = 4 + ($random(seed) & 127);
      dint_len = (i % 4 == 3) ? 8'hff : d[7:0];
      notes.push_back({in_neg, i % 4 == 3, (i % 4 == 3) ? DMAX - 1 : d});
      wait_phase(2'h2);
    end
    $display("test conversions done");
    // Parked in auto zero while run_en is low
    wait_phase(2'h0);
    run_en = 1'b0;
    dint_len = 8'hff;
    repeat (100) @(posedge clk) check(phase_sel === 2'h0, "park");
    #1 run_en = 1'b1;
    $display("test park done");
    // Reset in mid-deintegration drops the conversion
    wait_phase(2'h3);
    repeat (5) @(posedge clk);
    #1 rstn = 1'b0;
    repeat (3) @(posedge clk);
    #1 check(phase_sel === 2'h2 && res_valid === 1'b0 && res_over === 1'b0, "reset state");
    rstn = 1'b1;
    wait_phase(2'h0);
    dint_len = 8'h05;
    notes.push_back({1'b1, 1'b0, 32'h0000_0005});
    in_neg = 1'b1;
    wait_phase(2'h2);
    repeat (3) @(posedge clk);
    check(notes.size() == 0, "results missing");
    $display("test reset done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("mismatch at %0t: watchdog", $time);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
